//--- bpwm_steer.sv
// Functional notes
// - half-bridge: A carries the waveform, B its complement.
// - half-bridge: output goes active only after the programmed delay count cycles.
// - delay longer than the active phase keeps that output inactive all cycle.
// - delay only on inactive-to-active; deactivation is immediate.
// - full-bridge: four outputs, only one steady and one modulated active.
// - forward: A steady active, D modulated, B and C inactive.
// - reverse: C steady active, B modulated, A and D inactive.
// - direction change takes effect from the next PWM cycle.
// - A and C switch early by 1, 4 or 16 oscillator periods by prescale; the code switches them 1, 1 or 4 instruction cycles early.
// - in the transition cycle B and D are held inactive.
// - no deadband delay in full-bridge configuration.
// - output latches correct after one whole PWM cycle from enable.
// - period flag sets at each period end; software waits for it.
// - two-bit polarity field picks active-high or active-low outputs.
// - delay count is eight bits, in instruction cycles.
// - config field: 00 single, 01 full forward, 10 half, 11 full reverse.
// - settings load at period start; delay loads at duty end or period start.
`timescale 1ns/1ps
module bpwm_steer
   import bpwm_pkg::*;
#(
   parameter int CNT_W = 16, // width of the period length counter
   parameter int DLY_W = 8 // width of the delay count
) (
   input wire logic mclk, // instruction clock
   input wire logic nrst, // asynchronous reset, active low
   input wire logic wb_cyc_i, // wishbone cycle
   input wire logic wb_stb_i, // wishbone strobe
   input wire logic wb_we_i, // wishbone write
   input wire logic [3:0] wb_adr_i, // wishbone byte address
   input wire logic [3:0] wb_sel_i, // wishbone byte selects
   input wire logic [31:0] wb_dat_i, // wishbone write data
   output logic [31:0] wb_dat_o, // wishbone read data
   output logic wb_ack_o, // wishbone acknowledge
   input wire logic pwm_in, // duty waveform from the generator
   input wire logic period_start, // pulse as the timebase resets
   input wire logic [1:0] timebase_prescale_select, // timebase prescale setting
   output logic [3:0] pin_o, // pin levels, d c b a
   output logic [3:0] pin_oe // pin drive enables, high drives
);
   // the shadowed settings only fit in one byte lane
   // refused at elaboration, so a bad build never reaches silicon
   if (CNT_W < 4 || DLY_W != 8) begin : g_bad_param
      $error("bpwm_steer: unsupported CNT_W or DLY_W");
   end

   localparam logic [DLY_W-1:0] DLY_MAX = '1;
   localparam logic [CNT_W-1:0] CNT_MAX = '1;
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   // saturating deadband counter step
   function automatic logic [DLY_W-1:0] db_step(input logic raw, input logic [DLY_W-1:0] c);
      return !raw ? '0 : ((c == DLY_MAX) ? c : c + DLY_W'(1));
   endfunction

   // software-visible state
   logic [7:0] ctrl_q;
   logic [DLY_W-1:0] delay_sw_q;
   logic [3:0] lat_q;
   logic [3:0] dir_q;
   logic flag_q;
   logic ack_q;
   logic [31:0] rdat_q;
   // working copies loaded at cycle boundaries; ac_fwd_q also loads early, at the lead point of a reversal
   bpwm_cfg_t mode_q;
   logic [1:0] pol_q;
   logic en_q;
   logic [DLY_W-1:0] delay_count_q;
   logic ac_fwd_q;
   // timing and output state
   logic pwm_q;
   logic [CNT_W-1:0] cyc_q;
   logic [CNT_W-1:0] len_q;
   logic [DLY_W-1:0] dba_q;
   logic [DLY_W-1:0] dbb_q;
   logic [3:0] out_q;
   logic [3:0] pin_q;
   // polarity that the latched outputs were built with, for the checks
   logic [1:0] pol_out_q;

   // bus decode
   wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
   wire wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
   wire wr_ctrl = wr_lane0 && (wb_adr_i == BPWM_ADR_CTRL);
   wire wr_delay = wr_lane0 && (wb_adr_i == BPWM_ADR_DELAY);
   wire wr_status = wr_lane0 && (wb_adr_i == BPWM_ADR_STATUS);
   wire wr_port = wr_lane0 && (wb_adr_i == BPWM_ADR_PORT);

   // shadow fields as software last wrote them
   wire bpwm_cfg_t sh_mode = bpwm_cfg_t'(ctrl_q[BPWM_CFG_LSB +: 2]);
   wire [1:0] sh_pol = ctrl_q[BPWM_POL_LSB +: 2];
   wire sh_en = ctrl_q[BPWM_EN_BIT];

   // full-bridge reversal pending until the next period start
   wire full_now = (mode_q == BPWM_FULL_FWD) || (mode_q == BPWM_FULL_REV);
   wire full_sh = (sh_mode == BPWM_FULL_FWD) || (sh_mode == BPWM_FULL_REV);
   wire chg_pend = en_q && full_now && full_sh && (sh_mode != mode_q);

   // lead of the steady outputs ahead of the period end
   wire [CNT_W-1:0] lead_cyc = (timebase_prescale_select == 2'b00) ? CNT_W'(BPWM_LEAD_CYC_P1) :
                              (timebase_prescale_select == 2'b01) ? CNT_W'(BPWM_LEAD_CYC_P4) :
                              CNT_W'(BPWM_LEAD_CYC_P16);
   // period length learnt from the previous period; the flip lands one edge after the hit,
   // so the hit sits one cycle earlier to give exactly lead cycles of the new direction
   wire lead_hit = chg_pend && (len_q > lead_cyc) && (cyc_q == len_q - lead_cyc - CNT_ONE);

   // duty boundary is the fall of the waveform
   wire duty_end = pwm_q && !pwm_in;
   wire delay_load = duty_end || period_start;

   // half-bridge raw phases and their delayed versions
   wire half_a_raw = pwm_in;
   wire half_b_raw = !pwm_in;
   wire half_a = half_a_raw && (dba_q >= delay_count_q);
   wire half_b = half_b_raw && (dbb_q >= delay_count_q);

   // logical (active-high) output levels for each configuration
   wire is_half = (mode_q == BPWM_HALF);
   wire is_single = (mode_q == BPWM_SINGLE);
   wire log_a = en_q && (is_single ? pwm_in : is_half ? half_a : (full_now && ac_fwd_q));
   wire log_c = en_q && full_now && !ac_fwd_q;
   wire log_b = en_q && (is_half ? half_b :
                         ((mode_q == BPWM_FULL_REV) && pwm_in && !chg_pend));
   wire log_d = en_q && (mode_q == BPWM_FULL_FWD) && pwm_in && !chg_pend;

   // polarity: bit 1 inverts A and C, bit 0 inverts B and D
   wire [3:0] pol_mask = {pol_q[0], pol_q[1], pol_q[0], pol_q[1]};
   wire [3:0] out_d = {log_d, log_c, log_b, log_a} ^ pol_mask;

   // pins show the unit while it runs, the port latch otherwise
   wire [3:0] pin_d = en_q ? out_q : lat_q;

   // read mux, unmapped offsets read as zero
   wire [31:0] rd_mux = (wb_adr_i == BPWM_ADR_CTRL) ? {24'h000000, ctrl_q} :
                        (wb_adr_i == BPWM_ADR_DELAY) ? {24'h000000, delay_sw_q} :
                        (wb_adr_i == BPWM_ADR_STATUS) ?
                           (32'(flag_q) << BPWM_ST_FLAG) | (32'(chg_pend) << BPWM_ST_PEND) |
                           (32'(mode_q) << BPWM_ST_MODE) :
                        (wb_adr_i == BPWM_ADR_PORT) ?
                           (32'(lat_q) << BPWM_PORT_LAT) | (32'(dir_q) << BPWM_PORT_DIR) :
                        32'h00000000;

   // bus slave: one ack per request, data registered with it
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h00000000;
      end else begin
         ack_q <= bus_req;
         rdat_q <= bus_req ? rd_mux : 32'h00000000;
      end
   end

   // software registers; lane 0 carries every field
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= BPWM_CTRL_RST;
         delay_sw_q <= BPWM_DELAY_RST;
         lat_q <= BPWM_LAT_RST;
         dir_q <= BPWM_DIR_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wb_dat_i[7:0];
         end
         if (wr_delay) begin
            delay_sw_q <= wb_dat_i[DLY_W-1:0];
         end
         if (wr_port) begin
            lat_q <= wb_dat_i[BPWM_PORT_LAT +: 4];
            dir_q <= wb_dat_i[BPWM_PORT_DIR +: 4];
         end
      end
   end

   // period flag: write one to clear, a new period end wins
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         flag_q <= 1'b0;
      end else if (period_start) begin
         flag_q <= 1'b1;
      end else if (wr_status && wb_dat_i[BPWM_ST_FLAG]) begin
         flag_q <= 1'b0;
      end
   end

   // working settings load at the period boundary to avoid glitches
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mode_q <= BPWM_SINGLE;
         pol_q <= 2'b00;
         en_q <= 1'b0;
      end else if (period_start) begin
         mode_q <= sh_mode;
         pol_q <= sh_pol;
         en_q <= sh_en;
      end
   end

   // delay loads at whichever boundary comes first
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         delay_count_q <= BPWM_DELAY_RST;
      end else if (delay_load) begin
         delay_count_q <= delay_sw_q;
      end
   end

   // steady output direction moves early on a reversal
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ac_fwd_q <= 1'b0;
      end else if (period_start) begin
         ac_fwd_q <= (sh_mode == BPWM_FULL_FWD);
      end else if (lead_hit) begin
         ac_fwd_q <= (sh_mode == BPWM_FULL_FWD);
      end
   end

   // cycle counter; length is remembered since the timebase hides it
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cyc_q <= '0;
         len_q <= '0;
      end else if (period_start) begin
         cyc_q <= '0;
         len_q <= (cyc_q == CNT_MAX) ? cyc_q : cyc_q + CNT_ONE;
      end else if (cyc_q != CNT_MAX) begin
         cyc_q <= cyc_q + CNT_ONE;
      end
   end

   // deadband counters restart whenever their phase drops
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dba_q <= '0;
         dbb_q <= '0;
         pwm_q <= 1'b0;
      end else begin
         dba_q <= db_step(half_a_raw, dba_q);
         dbb_q <= db_step(half_b_raw, dbb_q);
         pwm_q <= pwm_in;
      end
   end

   // output latches and pin drivers from flip-flops
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         out_q <= 4'h0;
         pin_q <= 4'h0;
         pol_out_q <= 2'b00;
      end else begin
         out_q <= out_d;
         pin_q <= pin_d;
         pol_out_q <= pol_q;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign pin_o = pin_q;
   // a pin drives only once software clears its direction bit
   assign pin_oe = ~dir_q;

   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   // active levels use the polarity the latch was built with, not the one loaded since
   wire [3:0] act = out_q ^ {pol_out_q[0], pol_out_q[1], pol_out_q[0], pol_out_q[1]};

   a_half_compl: assert property (
      en_q && is_half && $stable(pol_q) && (delay_count_q == '0) && !period_start
      |=> act[1] == !act[0])
      else $error("half-bridge B is not the complement of A");

   a_half_delay: assert property (
      en_q && is_half && $rose(pwm_in) && (delay_count_q == DLY_W'(3)) && !$changed(mode_q)
      ##1 (pwm_in && $stable(delay_count_q))[*3] |-> !act[0])
      else $error("A went active before the deadband ran out");

   a_half_fall: assert property (
      en_q && is_half && $fell(pwm_in) && $stable(mode_q) && $stable(pol_q) |=> !act[0])
      else $error("A did not drop at once");

   a_full_two: assert property (
      en_q && full_now && $stable(pol_q) |=> $countones(act) <= 2)
      else $error("more than two full-bridge outputs active");

   a_fwd_map: assert property (
      en_q && (mode_q == BPWM_FULL_FWD) && !chg_pend && ac_fwd_q && $stable(pol_q)
      |=> !act[1] && !act[2])
      else $error("forward mode drives B or C");

   a_rev_map: assert property (
      en_q && (mode_q == BPWM_FULL_REV) && !ac_fwd_q && $stable(pol_q)
      |=> !act[0] && !act[3])
      else $error("reverse mode drives A or D");

   a_mod_quiet: assert property (
      chg_pend && $stable(pol_q) |=> !act[1] && !act[3])
      else $error("modulated output active during reversal");

   a_lead_flip: assert property (
      lead_hit && !period_start |=> ac_fwd_q == (sh_mode == BPWM_FULL_FWD))
      else $error("steady outputs missed the early switch");

   a_mode_hold: assert property (
      !period_start |=> $stable(mode_q) && $stable(pol_q))
      else $error("settings changed away from a period boundary");

   // single output: A follows the waveform, the rest stay inactive
   a_single_map: assert property (
      en_q && is_single && !period_start |=> act[0] == $past(pwm_in) && act[3:1] == 3'b000)
      else $error("single output mode mapping wrong");

   // disabled or fresh from reset: nothing active whatever the polarity
   a_idle_quiet: assert property (
      !en_q |=> act == 4'h0)
      else $error("output active while the unit is disabled");

   // full bridge forward: D follows the waveform with no delay
   a_fwd_nodelay: assert property (
      en_q && (mode_q == BPWM_FULL_FWD) && !chg_pend |=> act[3] == $past(pwm_in))
      else $error("forward modulated output delayed");

   // full bridge reverse: B follows the waveform with no delay
   a_rev_mod: assert property (
      en_q && (mode_q == BPWM_FULL_REV) && !chg_pend |=> act[1] == $past(pwm_in))
      else $error("reverse modulated output wrong");

   // pins carry the latches while the unit runs
   a_pin_follow: assert property (
      en_q |=> pin_o == $past(out_q))
      else $error("pins do not follow the output latches");

   a_flag_set: assert property (
      period_start |=> flag_q ##1 (flag_q || $past(wr_status)))
      else $error("period flag not set at period end");
endmodule

//--- bpwm_pkg.sv
package bpwm_pkg;
   // register byte offsets on the wishbone slave
   localparam logic [3:0] BPWM_ADR_CTRL = 4'h0;
   localparam logic [3:0] BPWM_ADR_DELAY = 4'h4;
   localparam logic [3:0] BPWM_ADR_STATUS = 4'h8;
   localparam logic [3:0] BPWM_ADR_PORT = 4'hC;
   // control register fields
   localparam int BPWM_CFG_LSB = 6;
   localparam int BPWM_EN_BIT = 2;
   localparam int BPWM_POL_LSB = 0;
   // status register fields
   localparam int BPWM_ST_FLAG = 0;
   localparam int BPWM_ST_PEND = 1;
   localparam int BPWM_ST_MODE = 4;
   // port register fields
   localparam int BPWM_PORT_LAT = 0;
   localparam int BPWM_PORT_DIR = 4;
   // reset values
   localparam logic [7:0] BPWM_CTRL_RST = 8'h00;
   localparam logic [7:0] BPWM_DELAY_RST = 8'h00;
   localparam logic [3:0] BPWM_LAT_RST = 4'h0;
   localparam logic [3:0] BPWM_DIR_RST = 4'hF;
   // direction-change lead in oscillator periods, per prescale setting
   localparam int BPWM_LEAD_TOSC_P1 = 1;
   localparam int BPWM_LEAD_TOSC_P4 = 4;
   localparam int BPWM_LEAD_TOSC_P16 = 16;
   localparam int BPWM_TOSC_PER_CYC = 4;
   // longest time rounds down, never below one cycle
   function automatic int bpwm_lead_cyc(input int tosc);
      int c;
      c = tosc / BPWM_TOSC_PER_CYC;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int BPWM_LEAD_CYC_P1 = bpwm_lead_cyc(BPWM_LEAD_TOSC_P1);
   localparam int BPWM_LEAD_CYC_P4 = bpwm_lead_cyc(BPWM_LEAD_TOSC_P4);
   localparam int BPWM_LEAD_CYC_P16 = bpwm_lead_cyc(BPWM_LEAD_TOSC_P16);
   // output configurations
   typedef enum logic [1:0] {
      BPWM_SINGLE = 2'b00,
      BPWM_FULL_FWD = 2'b01,
      BPWM_HALF = 2'b10,
      BPWM_FULL_REV = 2'b11
   } bpwm_cfg_t;
endpackage

//--- bpwm_bridge_model.sv
`timescale 1ns/1ps
// external bridge drivers, every gate input held low by a pull-down
module bpwm_bridge_model (
   input wire logic mclk, // sampling clock
   input wire logic [3:0] pin_o, // pin levels, d c b a
   input wire logic [3:0] pin_oe, // pin drive enables
   output logic [3:0] gate, // gate levels seen by the switches
   output int shoot // cycles with both switches of leg a-b on
);
   // an undriven pin falls to its pull-down, so the switch stays off
   assign gate = pin_o & pin_oe;
   initial shoot = 0;
   // a leg shorts when both its switches conduct at once
   always @(posedge mclk) begin
      if (gate[0] === 1'b1 && gate[1] === 1'b1) begin
         shoot <= shoot + 1;
      end
   end
endmodule

//--- bridge_pwm_output_steering_tb.sv
`timescale 1ns/1ps
module bridge_pwm_output_steering_tb;
   import bpwm_pkg::*;
   localparam int PER = 20;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic wb_ack_o;
   logic pwm_in = 1'b0, period_start = 1'b0;
   logic [1:0] timebase_prescale_select = 2'b00, pol = 2'b00;
   logic [3:0] pin_o, pin_oe, gate, act;
   int shoot, cnt = 0, duty = 0, mismatches = 0, n_tests = 0;
   int acc [4] = '{0, 0, 0, 0};
   int win [4];
   event win_ev;
   always #5 mclk = ~mclk;
   bpwm_steer i_dut (.mclk(mclk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .pwm_in(pwm_in), .period_start(period_start), .timebase_prescale_select(timebase_prescale_select),
      .pin_o(pin_o), .pin_oe(pin_oe));
   bpwm_bridge_model i_drv (.mclk(mclk), .pin_o(pin_o), .pin_oe(pin_oe), .gate(gate), .shoot(shoot));
   // timebase stand-in: one start pulse and a leading duty phase per period
   always @(posedge mclk) begin
      cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
      period_start <= (cnt == PER - 1);
      pwm_in <= (cnt != PER - 1) && (cnt < duty);
   end
   assign act = pin_o ^ {pol[0], pol[1], pol[0], pol[1]};
   // active cycles per pin, window shifted by the two-cycle pin latency
   always @(posedge mclk) begin
      if (cnt == 3) begin
         win = acc;
         acc = '{0, 0, 0, 0};
         ->win_ev;
      end
      for (int i = 0; i < 4; i++) acc[i] += (act[i] === 1'b1);
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // classic single cycle, entered just after a rising edge
   task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] dat);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= {24'h0, dat};
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic set_mode(input bpwm_cfg_t cfg, input logic [1:0] p, input logic [7:0] dly, input int dty);
      wb(1'b1, BPWM_ADR_DELAY, dly);
      wb(1'b1, BPWM_ADR_CTRL, {cfg, 3'b000, 1'b1, p});
      pol = p;
      duty = dty;
      repeat (3) @(win_ev);
   endtask
   task automatic t_reset;
      check(pin_oe, 4'h0);
      wb(1'b0, BPWM_ADR_CTRL, 8'h00);
      check(rd, 32'h0);
      wb(1'b0, BPWM_ADR_PORT, 8'h00);
      check(rd, 32'hF0);
      wb(1'b1, BPWM_ADR_DELAY, 8'hA5);
      wb(1'b0, BPWM_ADR_DELAY, 8'h00);
      check(rd, 32'hA5);
      wb(1'b1, 4'h2, 8'hFF);
      wb(1'b0, 4'h2, 8'h00);
      check(rd, 32'h0);
   endtask
   // enable with pins as inputs, wait for the period flag, then drive
   task automatic t_start;
      set_mode(BPWM_SINGLE, 2'b00, 8'h00, 8);
      check(win[0], 8);
      @(win_ev);
      wb(1'b1, BPWM_ADR_STATUS, 8'h01);
      wb(1'b0, BPWM_ADR_STATUS, 8'h00);
      check(rd[BPWM_ST_FLAG], 1'b0);
      set_mode(BPWM_HALF, 2'b00, 8'h00, 8);
      do wb(1'b0, BPWM_ADR_STATUS, 8'h00); while (rd[BPWM_ST_FLAG] !== 1'b1);
      check(gate, 4'h0);
      @(win_ev);
      check(win[0], 8);
      check(win[1], PER - 8);
      wb(1'b1, BPWM_ADR_PORT, 8'h00);
      @(win_ev);
      check(pin_oe, 4'hF);
      check(shoot, 0);
   endtask
   task automatic t_half;
      int d [4] = '{3, 10, 3, 0};
      logic [1:0] pv [4] = '{2'b00, 2'b00, 2'b11, 2'b00};
      int ea, eb;
      for (int i = 0; i < 4; i++) begin
         set_mode(BPWM_HALF, pv[i], d[i][7:0], 8);
         ea = (8 > d[i]) ? 8 - d[i] : 0;
         eb = (PER - 8 > d[i]) ? PER - 8 - d[i] : 0;
         check(win[0], ea);
         check(win[1], eb);
      end
   endtask
   task automatic t_full;
      set_mode(BPWM_FULL_FWD, 2'b00, 8'h05, 8);
      check({win[3][7:0], win[2][7:0], win[1][7:0], win[0][7:0]}, {8'd8, 8'd0, 8'd0, 8'(PER)});
      set_mode(BPWM_FULL_REV, 2'b01, 8'h05, 8);
      check({win[3][7:0], win[2][7:0], win[1][7:0], win[0][7:0]}, {8'd0, 8'(PER), 8'd8, 8'd0});
   endtask
   // reversal written late in a period, after the duty phase ended
   task automatic t_dir;
      logic [1:0] ps [4] = '{2'b10, 2'b00, 2'b01, 2'b11};
      int ld [4] = '{BPWM_LEAD_CYC_P16, BPWM_LEAD_CYC_P1, BPWM_LEAD_CYC_P4, BPWM_LEAD_CYC_P16};
      bpwm_cfg_t cf;
      int s, m, os, om;
      for (int i = 0; i < 4; i++) begin
         cf = (i % 2 == 0) ? BPWM_FULL_FWD : BPWM_FULL_REV;
         s = (cf == BPWM_FULL_FWD) ? 0 : 2;
         m = (cf == BPWM_FULL_FWD) ? 3 : 1;
         os = 2 - s;
         om = 4 - m;
         timebase_prescale_select <= ps[i];
         repeat (2) @(win_ev);
         repeat (8) @(posedge mclk);
         wb(1'b1, BPWM_ADR_CTRL, {cf, 3'b000, 1'b1, pol});
         wb(1'b0, BPWM_ADR_STATUS, 8'h00);
         check(rd[BPWM_ST_PEND], 1'b1);
         @(win_ev);
         check(win[s], ld[i]);
         check(win[os], PER - ld[i]);
         check(win[m], 0);
         check(win[om], 8);
         @(win_ev);
         check({win[s][7:0], win[m][7:0], win[os][7:0], win[om][7:0]}, {8'(PER), 8'd8, 8'd0, 8'd0});
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // about 900 cycles expected; a generous margin cuts a hang
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      finish_test;
   end
   initial begin
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      t_reset;
      t_start;
      t_half;
      t_full;
      t_dir;
      finish_test;
   end
endmodule
